//--- inc/t8ccu_defs.vh
// t8ccu_defs.vh: register map, field positions, mode codes and reset values
// for the 8-bit timer/counter with one compare unit.
// assumes an apb slave with 32-bit data, one aligned word per register.
`ifndef T8CCU_DEFS_VH
`define T8CCU_DEFS_VH

// register byte addresses
`define T8_ADDR_CTRL 12'h000
`define T8_ADDR_CNT 12'h004
`define T8_ADDR_CMP 12'h008
`define T8_ADDR_FLAG 12'h00c
`define T8_ADDR_MASK 12'h010
`define T8_ADDR_ASYNC 12'h014
`define T8_ADDR_STAT 12'h018

// control register fields
`define T8_CS_LSB 0
`define T8_CS_MSB 2
`define T8_WGM_LSB 3
`define T8_WGM_MSB 4
`define T8_COM_LSB 5
`define T8_COM_MSB 6
`define T8_FOC_BIT 7
`define T8_DDR_BIT 8
`define T8_PORT_BIT 9

// flag and mask bits
`define T8_OVF_BIT 0
`define T8_OCF_BIT 1

// status register bits
`define T8_DIR_BIT 0
`define T8_OC_BIT 1
`define T8_TOP_BIT 2
`define T8_BOT_BIT 3

// waveform modes
`define T8_WGM_NORMAL 2'h0
`define T8_WGM_PCPWM 2'h1
`define T8_WGM_CTC 2'h2
`define T8_WGM_FAST 2'h3

// output actions
`define T8_COM_NONE 2'h0
`define T8_COM_TOGGLE 2'h1
`define T8_COM_CLEAR 2'h2
`define T8_COM_SET 2'h3

// clock selects
`define T8_CS_STOP 3'h0
`define T8_CS_DIRECT 3'h1

// count extremes and reset values
`define T8_MAX 8'hff
`define T8_BOTTOM 8'h00
`define T8_ONE 8'h01
`define T8_RESET8 8'h00
`define T8_RESET32 32'h0000_0000

`endif

//--- hdl/t8ccu_timer.v
// t8ccu_timer.v: 8-bit bidirectional timer/counter with one output compare
// unit, compare-match output pin override and an apb register slave.
// assumes prescaler taps come from outside on sys_clk_in as one-cycle ticks;
// the oscillator input arrives on a pin and is resynchronised here.
`timescale 1ns/1ps
`include "t8ccu_defs.vh"

module t8ccu_timer (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [11:0] paddr_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire [7:1] prescale_tick_in,
  input wire oscillator_pin_one_in,
  input wire compare_irq_ack_in,
  input wire overflow_irq_ack_in,
  output reg compare_output_out,
  output reg compare_output_oe_out,
  output reg compare_irq_out,
  output reg overflow_irq_out
);

  // software-visible state
  reg [2:0] clock_source_select_q;   // timer clock choice
  reg [1:0] waveform_mode_field_q;   // counting sequence
  reg [1:0] output_action_field_q;   // compare output action
  reg output_pin_direction_bit_q;    // pin drives when set
  reg port_value_q;                  // general port output value
  reg async_clock_enable_q;          // oscillator clocks the timer
  reg compare_irq_enable_q;          // compare interrupt mask
  reg overflow_irq_enable_q;         // overflow interrupt mask
  reg compare_match_flag_q;          // sticky compare event
  reg overflow_flag_q;               // sticky overflow event
  // counter and compare path
  reg [7:0] counter_value_q;         // the count
  reg count_down_q;                  // dual-slope direction
  reg [7:0] compare_value_q;         // active compare register
  reg [7:0] compare_buffer_q;        // cpu side buffer in pwm modes
  reg compare_state_q;               // internal compare output state
  reg block_match_q;                 // match blocked until next tick
  reg match_pending_q;               // match waiting to set the flag
  // oscillator pin synchroniser, three stages
  reg osc_s1_q;
  reg osc_s2_q;
  reg osc_s3_q;
  reg osc_prev_q;                    // last agreed level

  // register map, one aligned 32-bit word each, data in the low bits:
  //   0x00 control: clock select [2:0], waveform mode [4:3], output action [6:5],
  //        force strobe [7] (write only, reads zero), direction bit [8], port value [9]
  //   0x04 counter value, readable and writable whether or not the timer runs
  //   0x08 compare value; in pwm modes this reaches the buffer copy instead
  //   0x0c flags: overflow [0], compare match [1]; writing one clears a flag
  //   0x10 interrupt enables: overflow [0], compare match [1]
  //   0x14 async clock enable [0]
  //   0x18 status, read only: direction [0], output state [1], at max [2], at bottom [3]
  // any other address answers with pslverr, ignores writes and reads zero.
  //
  // bus timing: read data is latched in the setup cycle and held through the
  // access phase; pready rises one cycle into the access phase, and a write
  // takes effect only at the edge where pready is seen high, so a held request
  // never applies a write twice. the force strobe depends on that, since a
  // second application would toggle the output back.
  // apb decode
  wire apb_access = psel_in & penable_in;
  wire apb_wr = apb_access & pready_out & pwrite_in & pstrb_in[0]; // write lands on the ready edge only
  wire wr_ctrl = apb_wr & (paddr_in == `T8_ADDR_CTRL);
  wire wr_cnt = apb_wr & (paddr_in == `T8_ADDR_CNT);
  wire wr_cmp = apb_wr & (paddr_in == `T8_ADDR_CMP);
  wire wr_flag = apb_wr & (paddr_in == `T8_ADDR_FLAG);
  wire wr_mask = apb_wr & (paddr_in == `T8_ADDR_MASK);
  wire wr_async = apb_wr & (paddr_in == `T8_ADDR_ASYNC);
  wire addr_ok = (paddr_in == `T8_ADDR_CTRL) | (paddr_in == `T8_ADDR_CNT) |
                 (paddr_in == `T8_ADDR_CMP) | (paddr_in == `T8_ADDR_FLAG) |
                 (paddr_in == `T8_ADDR_MASK) | (paddr_in == `T8_ADDR_ASYNC) |
                 (paddr_in == `T8_ADDR_STAT);

  // mode decode
  wire pwm_mode = (waveform_mode_field_q == `T8_WGM_PCPWM) |
                  (waveform_mode_field_q == `T8_WGM_FAST);
  wire at_max = (counter_value_q == `T8_MAX);
  wire at_bottom = (counter_value_q == `T8_BOTTOM);
  wire match = (counter_value_q == compare_value_q);

  // three stages on the oscillator pin; a level counts only once the second and
  // third stage agree, and osc_prev_q keeps the last agreed level so that each
  // rising edge gives exactly one tick.
  // oscillator edge: second and third stage agree on a new level
  wire osc_agree = (osc_s2_q == osc_s3_q);
  wire osc_rise = osc_agree & osc_s3_q & ~osc_prev_q;

  // the timer clock is a one-cycle enable on sys_clk_in rather than a real clock,
  // so every register stays in one domain. select zero gives no ticks at all;
  // select one ticks every cycle; higher selects take the matching prescaler tap.
  // with the async enable set, each agreed rising edge of the oscillator pin is
  // the tick whatever nonzero select is chosen, and the prescaler is bypassed.
  // hazard: the oscillator must stay well below half the system clock, or edges
  // are lost in the synchroniser.
  // timer clock tick selection
  reg tick;
  always @* begin
    tick = 1'b0;
    if (clock_source_select_q == `T8_CS_STOP) begin
      tick = 1'b0;
    end else if (async_clock_enable_q) begin
      tick = osc_rise;
    end else if (clock_source_select_q == `T8_CS_DIRECT) begin
      tick = 1'b1;
    end else begin
      tick = prescale_tick_in[clock_source_select_q];
    end
  end

  // next counter value and direction per mode
  reg [7:0] cnt_next;
  reg dir_next;
  reg ovf_event;
  reg cmp_reload;
  always @* begin
    cnt_next = counter_value_q + `T8_ONE;
    dir_next = count_down_q;
    ovf_event = 1'b0;
    cmp_reload = 1'b0;
    case (waveform_mode_field_q)
      `T8_WGM_NORMAL: begin
        dir_next = 1'b0;
        ovf_event = at_max;
      end
      `T8_WGM_CTC: begin
        dir_next = 1'b0;
        if (match) begin
          cnt_next = `T8_BOTTOM;
        end
        ovf_event = at_max;
      end
      `T8_WGM_FAST: begin
        dir_next = 1'b0;
        ovf_event = at_max;
        cmp_reload = at_max;
      end
      `T8_WGM_PCPWM: begin
        if (at_max) begin
          dir_next = 1'b1;
        end else if (at_bottom) begin
          dir_next = 1'b0;
        end
        cnt_next = dir_next ? (counter_value_q - `T8_ONE) : (counter_value_q + `T8_ONE);
        ovf_event = at_bottom & count_down_q;
        cmp_reload = at_max;
      end
      default: begin
        dir_next = 1'b0;
      end
    endcase
  end

  // the action field is read as it stands, so a new setting applies at the next
  // match. a force strobe written together with a new action field still uses
  // the old one; software writes the action first and then forces. in pwm modes
  // the strobe is ignored.
  // compare output action on a match or force
  wire real_match = tick & match & ~block_match_q;
  wire force_cmp = wr_ctrl & pwdata_in[`T8_FOC_BIT] & ~pwm_mode;
  reg oc_next;
  always @* begin
    oc_next = compare_state_q;
    if (output_action_field_q == `T8_COM_NONE) begin
      oc_next = compare_state_q;
    end else if (!pwm_mode) begin
      if (real_match | force_cmp) begin
        case (output_action_field_q)
          `T8_COM_TOGGLE: oc_next = ~compare_state_q;
          `T8_COM_CLEAR: oc_next = 1'b0;
          `T8_COM_SET: oc_next = 1'b1;
          default: oc_next = compare_state_q;
        endcase
      end
    end else if (output_action_field_q == `T8_COM_TOGGLE) begin
      if (real_match) begin
        oc_next = ~compare_state_q;
      end
    end else if (waveform_mode_field_q == `T8_WGM_FAST) begin
      // non-inverted clears on match, sets at bottom; inverted opposite
      if (real_match) begin
        oc_next = (output_action_field_q == `T8_COM_SET);
      end else if (tick & at_max) begin
        oc_next = (output_action_field_q == `T8_COM_CLEAR);
      end
    end else begin
      // phase correct: up-count match clears (non-inverted), down sets
      if (real_match) begin
        oc_next = (output_action_field_q == `T8_COM_SET) ^ count_down_q;
      end
    end
  end

  // oscillator pin synchroniser
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_s1_q <= oscillator_pin_one_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      if (osc_agree) begin
        osc_prev_q <= osc_s3_q;
      end
    end
  end

  // configuration registers
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      clock_source_select_q <= `T8_CS_STOP;
      waveform_mode_field_q <= `T8_WGM_NORMAL;
      output_action_field_q <= `T8_COM_NONE;
      output_pin_direction_bit_q <= 1'b0;
      port_value_q <= 1'b0;
      async_clock_enable_q <= 1'b0;
      compare_irq_enable_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        clock_source_select_q <= pwdata_in[`T8_CS_MSB:`T8_CS_LSB];
        waveform_mode_field_q <= pwdata_in[`T8_WGM_MSB:`T8_WGM_LSB];
        output_action_field_q <= pwdata_in[`T8_COM_MSB:`T8_COM_LSB];
        output_pin_direction_bit_q <= pwdata_in[`T8_DDR_BIT];
        port_value_q <= pwdata_in[`T8_PORT_BIT];
      end
      if (wr_async) begin
        async_clock_enable_q <= pwdata_in[0];
      end
      if (wr_mask) begin
        overflow_irq_enable_q <= pwdata_in[`T8_OVF_BIT];
        compare_irq_enable_q <= pwdata_in[`T8_OCF_BIT];
      end
    end
  end

  // a cpu write to the counter wins over any tick in the same cycle and arms
  // the match block, which lasts until the next tick, so a stopped timer keeps
  // its block. the compare flag is set one tick after the match through
  // match_pending_q. where a hardware set and a clear land in one cycle the set
  // wins, so no event is lost. limitation: a counter write of the compare value
  // hides that match, and a counter write in the same cycle as an overflow tick hides
  // that overflow; software has to avoid both.
  // counter, compare registers, flags
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      counter_value_q <= `T8_RESET8;
      count_down_q <= 1'b0;
      compare_value_q <= `T8_RESET8;
      compare_buffer_q <= `T8_RESET8;
      compare_state_q <= 1'b0;
      block_match_q <= 1'b0;
      match_pending_q <= 1'b0;
      compare_match_flag_q <= 1'b0;
      overflow_flag_q <= 1'b0;
    end else begin
      compare_state_q <= oc_next;
      if (wr_cnt) begin
        counter_value_q <= pwdata_in[7:0];
        block_match_q <= 1'b1;
      end else if (tick) begin
        counter_value_q <= cnt_next;
        count_down_q <= dir_next;
        block_match_q <= 1'b0;
      end
      // buffered or direct compare writes
      if (wr_cmp & ~pwm_mode) begin
        compare_value_q <= pwdata_in[7:0];
        compare_buffer_q <= pwdata_in[7:0];
      end else if (wr_cmp) begin
        compare_buffer_q <= pwdata_in[7:0];
      end
      if (pwm_mode & tick & cmp_reload) begin
        compare_value_q <= compare_buffer_q;
      end
      // match sets the flag on the following tick
      if (tick) begin
        match_pending_q <= real_match;
      end
      // set beats clear for both flags
      if (tick & match_pending_q) begin
        compare_match_flag_q <= 1'b1;
      end else if (compare_irq_ack_in | (wr_flag & pwdata_in[`T8_OCF_BIT])) begin
        compare_match_flag_q <= 1'b0;
      end
      if (tick & ovf_event & ~wr_cnt) begin
        overflow_flag_q <= 1'b1;
      end else if (overflow_irq_ack_in | (wr_flag & pwdata_in[`T8_OVF_BIT])) begin
        overflow_flag_q <= 1'b0;
      end
    end
  end

  // the pin value is the next output state when any action bit is set, so the
  // pin and the internal state change on the same edge; with action zero the
  // port value bit shows instead. the pin enable follows the direction bit in
  // every mode. interrupt lines are flag and enable, one cycle late.
  // pin, interrupt and apb outputs, all registered
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      compare_output_out <= 1'b0;
      compare_output_oe_out <= 1'b0;
      compare_irq_out <= 1'b0;
      overflow_irq_out <= 1'b0;
      prdata_out <= `T8_RESET32;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      // port override when either action bit set
      compare_output_out <= (output_action_field_q != `T8_COM_NONE) ? oc_next : port_value_q;
      compare_output_oe_out <= output_pin_direction_bit_q;
      compare_irq_out <= compare_irq_enable_q & compare_match_flag_q;
      overflow_irq_out <= overflow_irq_enable_q & overflow_flag_q;
      // one wait state: pready rises in the second access cycle
      pready_out <= apb_access & ~pready_out;
      pslverr_out <= apb_access & ~pready_out & ~addr_ok;
      prdata_out <= `T8_RESET32;
      if (psel_in & ~penable_in & ~pwrite_in) begin
        case (paddr_in)
          `T8_ADDR_CTRL: prdata_out <= {22'h0, port_value_q, output_pin_direction_bit_q, 1'b0,
                                        output_action_field_q, waveform_mode_field_q, clock_source_select_q};
          `T8_ADDR_CNT: prdata_out <= {24'h0, counter_value_q};
          `T8_ADDR_CMP: prdata_out <= {24'h0, pwm_mode ? compare_buffer_q : compare_value_q};
          `T8_ADDR_FLAG: prdata_out <= {30'h0, compare_match_flag_q, overflow_flag_q};
          `T8_ADDR_MASK: prdata_out <= {30'h0, compare_irq_enable_q, overflow_irq_enable_q};
          `T8_ADDR_ASYNC: prdata_out <= {31'h0, async_clock_enable_q};
          `T8_ADDR_STAT: prdata_out <= {28'h0, at_bottom, at_max, compare_state_q, count_down_q};
          default: prdata_out <= `T8_RESET32;
        endcase
      end else if (apb_access) begin
        prdata_out <= prdata_out;
      end
    end
  end

endmodule // t8ccu_timer

//--- testbench/t8ccu_timer_assertions.sv
// t8ccu_timer_assertions.sv: port-level checker for the 8-bit timer.
// assumes it is bound onto t8ccu_timer and sees only that module's ports.
`timescale 1ns/1ps
`include "t8ccu_defs.vh"

module t8ccu_timer_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [7:1] prescale_tick_in,
  input wire logic oscillator_pin_one_in,
  input wire logic compare_irq_ack_in,
  input wire logic overflow_irq_ack_in,
  input wire logic compare_output_out,
  input wire logic compare_output_oe_out,
  input wire logic compare_irq_out,
  input wire logic overflow_irq_out
);
  default clocking dc @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  // first access cycle, still waiting for the answer
  sequence s_acc;
    psel_in && penable_in && !pready_out;
  endsequence

  wire wr_w = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0]; // write lands at ready
  logic [1:0] age_q; // cycles since the last control or mask write
  logic ddr_q; // expected direction bit
  logic port_q; // expected port value bit
  logic [1:0] com_q; // expected action field
  logic [1:0] mask_q; // expected interrupt enables

  // shadow of the fields that steer the pins and interrupt lines
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      age_q <= 2'h3;
      ddr_q <= 1'h0;
      port_q <= 1'h0;
      com_q <= 2'h0;
      mask_q <= 2'h0;
    end else if (wr_w && paddr_in == `T8_ADDR_CTRL) begin
      age_q <= 2'h0;
      ddr_q <= pwdata_in[`T8_DDR_BIT];
      port_q <= pwdata_in[`T8_PORT_BIT];
      com_q <= pwdata_in[`T8_COM_MSB:`T8_COM_LSB];
    end else if (wr_w && paddr_in == `T8_ADDR_MASK) begin
      age_q <= 2'h0;
      mask_q <= pwdata_in[1:0];
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end

  a_reset_quiet: assert property ($fell(rst_in) |-> !pready_out && !pslverr_out && !compare_output_out
    && !compare_output_oe_out && !compare_irq_out && !overflow_irq_out) else $error("outputs not idle after reset");
  a_good_addr: assert property (s_acc and paddr_in <= `T8_ADDR_STAT && paddr_in[1:0] == 2'h0
    |=> pready_out && !pslverr_out) else $error("mapped access not answered cleanly");
  a_bad_addr: assert property (s_acc and paddr_in > `T8_ADDR_STAT |=> pready_out && pslverr_out)
    else $error("unmapped access without error");
  a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in)) else $error("ready without access");
  a_err_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  a_dir_follows: assert property (age_q >= 2'h2 |-> compare_output_oe_out == ddr_q)
    else $error("pin enable differs from direction bit");
  a_port_value: assert property (age_q >= 2'h2 && com_q == 2'h0 |-> compare_output_out == port_q)
    else $error("pin differs from port value");
  a_cmp_masked: assert property (age_q >= 2'h2 && !mask_q[1] |-> !compare_irq_out)
    else $error("masked compare interrupt raised");
  a_ovf_masked: assert property (age_q >= 2'h2 && !mask_q[0] |-> !overflow_irq_out)
    else $error("masked overflow interrupt raised");
endmodule // t8ccu_timer_checker

bind t8ccu_timer t8ccu_timer_checker t8ccu_timer_checker_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .prescale_tick_in(prescale_tick_in), .oscillator_pin_one_in(oscillator_pin_one_in),
  .compare_irq_ack_in(compare_irq_ack_in), .overflow_irq_ack_in(overflow_irq_ack_in),
  .compare_output_out(compare_output_out), .compare_output_oe_out(compare_output_oe_out),
  .compare_irq_out(compare_irq_out), .overflow_irq_out(overflow_irq_out));

//--- testbench/t8ccu_timer_tb.sv
// t8ccu_timer_tb.sv: self-checking bench for the 8-bit timer over apb.
// assumes the checker is bound in; timer ticks come from prescale tap 2, or from the oscillator pin in the async test.
`timescale 1ns/1ps
`include "t8ccu_defs.vh"

module t8ccu_timer_tb;
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [11:0] paddr_in = 12'h0;
  logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'hf;
  logic [7:1] prescale_tick_in = 7'h0;
  logic oscillator_pin_one_in = 1'h0, compare_irq_ack_in = 1'h0, overflow_irq_ack_in = 1'h0;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, compare_output_out, compare_output_oe_out, compare_irq_out, overflow_irq_out;
  logic [31:0] rdat; // last read data
  logic berr; // last error response
  int failures = 0, checks = 0, cycles = 0;

  t8ccu_timer t8ccu_timer_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .paddr_in(paddr_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prescale_tick_in(prescale_tick_in), .oscillator_pin_one_in(oscillator_pin_one_in),
    .compare_irq_ack_in(compare_irq_ack_in), .overflow_irq_ack_in(overflow_irq_ack_in),
    .compare_output_out(compare_output_out), .compare_output_oe_out(compare_output_oe_out),
    .compare_irq_out(compare_irq_out), .overflow_irq_out(overflow_irq_out));

  // 125 mhz clock
  initial begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  task automatic close_out;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until ready is sampled high
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    psel_in <= 1'h1;
    @(posedge sys_clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge sys_clk_in);
    end while (pready_out !== 1'b1);
    rdat = prdata_out;
    berr = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'h1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    chk(rdat, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // n one-cycle timer ticks on tap 2, spaced by an idle cycle
  task automatic tk(input int n);
    repeat (n) begin
      prescale_tick_in[2] <= 1'h1;
      @(posedge sys_clk_in);
      prescale_tick_in[2] <= 1'h0;
      @(posedge sys_clk_in);
    end
  endtask

  // reset values, then an unmapped read
  task automatic t_reset;
    for (int a = 0; a < 24; a += 4) rdc(a[11:0], 32'h0);
    bus(12'h020, 1'h0, 32'h0);
    chk({31'h0, berr}, 32'h1);
    chk(rdat, 32'h0);
  endtask

  // normal wrap with overflow, then stopped hold
  task automatic t_normal;
    wr(`T8_ADDR_CTRL, 32'h002);
    wr(`T8_ADDR_CNT, 32'h0fe);
    tk(1);
    rdc(`T8_ADDR_CNT, 32'h0ff);
    rdc(`T8_ADDR_FLAG, 32'h0);
    tk(1);
    rdc(`T8_ADDR_CNT, 32'h0);
    rdc(`T8_ADDR_FLAG, 32'h1);
    wr(`T8_ADDR_MASK, 32'h1);
    wt(2);
    chk({31'h0, overflow_irq_out}, 32'h1);
    overflow_irq_ack_in <= 1'h1;
    @(posedge sys_clk_in);
    overflow_irq_ack_in <= 1'h0;
    wt(3);
    chk({31'h0, overflow_irq_out}, 32'h0);
    wr(`T8_ADDR_MASK, 32'h0);
    wr(`T8_ADDR_CTRL, 32'h0);
    wr(`T8_ADDR_CNT, 32'h033);
    tk(2);
    rdc(`T8_ADDR_CNT, 32'h033);
    wr(`T8_ADDR_FLAG, 32'h3);
    rdc(`T8_ADDR_FLAG, 32'h0);
  endtask

  // blocked match, delayed flag, interrupt and its acknowledge
  task automatic t_match;
    wr(`T8_ADDR_CTRL, 32'h002);
    wr(`T8_ADDR_CMP, 32'h010);
    wr(`T8_ADDR_CNT, 32'h010);
    tk(3);
    rdc(`T8_ADDR_FLAG, 32'h0);
    wr(`T8_ADDR_CNT, 32'h00f); // counter written off the compare value
    tk(1);
    rdc(`T8_ADDR_FLAG, 32'h0);
    tk(2);
    rdc(`T8_ADDR_FLAG, 32'h2);
    wr(`T8_ADDR_MASK, 32'h2);
    wt(3);
    chk({31'h0, compare_irq_out}, 32'h1);
    compare_irq_ack_in <= 1'h1;
    @(posedge sys_clk_in);
    compare_irq_ack_in <= 1'h0;
    wt(3);
    chk({31'h0, compare_irq_out}, 32'h0);
    rdc(`T8_ADDR_FLAG, 32'h0);
    wr(`T8_ADDR_MASK, 32'h0);
  endtask

  // fast mode: compare writes go to the buffer until bottom
  task automatic t_fast;
    wr(`T8_ADDR_CTRL, 32'h01a);
    wr(`T8_ADDR_CMP, 32'h040);
    wr(`T8_ADDR_CNT, 32'h00e);
    tk(4);
    rdc(`T8_ADDR_FLAG, 32'h2);
    wr(`T8_ADDR_CNT, 32'h0fe);
    tk(2);
    rdc(`T8_ADDR_CNT, 32'h0);
    rdc(`T8_ADDR_FLAG, 32'h3);
    wr(`T8_ADDR_FLAG, 32'h3);
    wr(`T8_ADDR_CNT, 32'h00f);
    tk(4);
    rdc(`T8_ADDR_FLAG, 32'h0);
  endtask

  // phase-correct turns at max; clear-on-match wraps at compare
  task automatic t_slopes;
    wr(`T8_ADDR_CTRL, 32'h00a);
    wr(`T8_ADDR_CNT, 32'h0fe);
    tk(2);
    rdc(`T8_ADDR_CNT, 32'h0fe);
    wr(`T8_ADDR_CTRL, 32'h012);
    wr(`T8_ADDR_CMP, 32'h003);
    wr(`T8_ADDR_CNT, 32'h001);
    tk(3);
    rdc(`T8_ADDR_CNT, 32'h0);
  endtask

  // forced actions, pin override and mode change keeping state
  task automatic t_pin;
    wr(`T8_ADDR_FLAG, 32'h3);
    wr(`T8_ADDR_CTRL, 32'h160);
    wt(2);
    chk({31'h0, compare_output_oe_out}, 32'h1);
    chk({31'h0, compare_output_out}, 32'h0);
    wr(`T8_ADDR_CTRL, 32'h1c0);
    wt(2);
    chk({31'h0, compare_output_out}, 32'h1);
    rdc(`T8_ADDR_FLAG, 32'h0);
    wr(`T8_ADDR_CTRL, 32'h1a0);
    wt(2);
    chk({31'h0, compare_output_out}, 32'h0);
    wr(`T8_ADDR_CTRL, 32'h1a0);
    wt(2);
    chk({31'h0, compare_output_out}, 32'h1);
    wr(`T8_ADDR_CTRL, 32'h118);
    bus(`T8_ADDR_STAT, 1'h0, 32'h0);
    chk(rdat & 32'h2, 32'h2);
    wr(`T8_ADDR_CTRL, 32'h200);
    wt(2);
    chk({30'h0, compare_output_out, compare_output_oe_out}, 32'h2);
  endtask

  // oscillator pin edges clock the counter when async is on
  task automatic t_async;
    wr(`T8_ADDR_CTRL, 32'h0);
    wr(`T8_ADDR_ASYNC, 32'h1);
    wr(`T8_ADDR_CNT, 32'h0);
    wr(`T8_ADDR_CTRL, 32'h001);
    repeat (3) begin
      oscillator_pin_one_in <= 1'h1;
      wt(6);
      oscillator_pin_one_in <= 1'h0;
      wt(6);
    end
    wr(`T8_ADDR_CTRL, 32'h0);
    rdc(`T8_ADDR_CNT, 32'h3);
    wr(`T8_ADDR_ASYNC, 32'h0);
  endtask

  initial begin
    wt(12);
    rst_in <= 1'h0;
    @(posedge sys_clk_in);
    t_reset;
    t_normal;
    t_match;
    t_fast;
    t_slopes;
    t_pin;
    t_async;
    close_out;
  end
endmodule // t8ccu_timer_tb
